// ===== pbc_port_ctrl.sv
// Management registers, resets and power modes of the port
//
// Behaviour
// - Port address latched from straps at reset
// - Unstrapped address comes up as zero
// - Hardware reset restores defaults, resamples straps
// - Control bit 15 resets standard registers, restraps
// - Reset bit reads one until done
// - Global reset restores all register defaults, keeps straps
// - Global restart leaves registers untouched
// - Pin or bit 11 powers down port
// - Power-down pin sets bit, holds it
// - Power-down ends on reset or clear
// - Deep power-down also stops crystal pad
// - Sleep field 10 selects active sleep
// - Sleep field 11 stops link pulses
// - Loopback returns transmit data to receive
// - Bits 6,13 pick speed without negotiation
// - Negotiation enable strapped, overrides speed, duplex
// - Isolate cuts MAC path, management stays
// - Restart negotiation bit self-clears on start
// - Bit 8 picks duplex, strapped default
// - Collision test echoes transmit enable
// - Bits 5:0 ignore writes, read zero
`timescale 1ns/1ps
module pbc_port_ctrl (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic rst_i,
   input wire logic hw_reset_n_i,
   input wire logic power_down_input_n_i,
   input wire logic [4:0] station_address_straps_i,
   input wire logic strap_narrow_i,
   input wire logic strap_an_enable_i,
   input wire logic strap_duplex_i,
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_o,
   input wire logic link_partner_i,
   input wire logic an_started_i,
   input wire logic [1:0] an_speed_i,
   input wire logic an_duplex_i,
   input wire pbc_pkg::pbc_mii_t mac_tx_i,
   input wire pbc_pkg::pbc_mii_t line_rx_i,
   input wire logic line_col_i,
   output pbc_pkg::pbc_mii_t mac_rx_o,
   output pbc_pkg::pbc_mii_t line_tx_o,
   output logic col_o,
   output logic [4:0] port_address_o,
   output logic power_down_o,
   output logic crystal_pad_off_o,
   output logic sleep_o,
   output logic nlp_tx_en_o,
   output logic [1:0] speed_o,
   output logic duplex_o,
   output logic an_enable_o,
   output logic an_restart_o,
   output logic circuit_restart_o
);
   typedef enum logic [2:0] {S_PRE, S_ST, S_OP, S_ADDR, S_TA, S_DATA} pbc_mdio_state_t;

   // Register selected by a frame address
   function automatic logic hits(input logic [4:0] a, input logic [4:0] off);
      hits = (a == off);
   endfunction

   pbc_pkg::pbc_strap_t straps_in;
   pbc_pkg::pbc_strap_t straps_q;
   logic [2:0] req;
   logic [2:0] busy;
   logic dev_rst;
   logic [15:0] bmc_reg;
   logic [15:0] bmc_next;
   logic [15:0] bmc_default;
   logic [15:0] pcfg_reg;
   logic [15:0] rd_data;
   logic mdc_reg;
   logic mdc_rise;
   pbc_mdio_state_t state_reg;
   logic [4:0] cnt_reg;
   logic [1:0] op_reg;
   logic [9:0] addr_reg;
   logic [15:0] sh_reg;
   logic match_reg;
   logic wr_stb;
   logic [4:0] wr_addr;
   logic [15:0] wr_data;
   logic wr_bmc;
   logic wr_gctrl;
   logic pd;

   // Narrow package drives only four address straps
   always_comb begin
      straps_in.addr = strap_narrow_i ? {1'b0, station_address_straps_i[3:0]} : station_address_straps_i;
      straps_in.an_enable = strap_an_enable_i;
      straps_in.duplex = strap_duplex_i;
   end

   pbc_reset_ctrl u_reset (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .rst_i(rst_i),
      .hw_reset_n_i(hw_reset_n_i),
      .req_i(req),
      .straps_i(straps_in),
      .straps_o(straps_q),
      .busy_o(busy),
      .dev_rst_o(dev_rst)
   );

   pbc_mii_path u_path (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .rst_i(dev_rst),
      .loopback_i(bmc_reg[pbc_pkg::BMC_LOOPBACK]),
      .isolate_i(bmc_reg[pbc_pkg::BMC_ISOLATE]),
      .col_test_i(bmc_reg[pbc_pkg::BMC_COL_TEST]),
      .mac_tx_i(mac_tx_i),
      .line_rx_i(line_rx_i),
      .line_col_i(line_col_i),
      .mac_rx_o(mac_rx_o),
      .line_tx_o(line_tx_o),
      .col_o(col_o)
   );

   // Clock edge detect on the management clock pin
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (dev_rst) begin
            mdc_reg <= 1'b0;
         end else begin
            mdc_reg <= mdc_i;
         end
      end
   end
   assign mdc_rise = mdc_i & ~mdc_reg;

   // Management frame receiver and read shifter
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         wr_stb <= 1'b0;
         if (dev_rst) begin
            state_reg <= S_PRE;
            cnt_reg <= 5'h00;
            op_reg <= 2'h0;
            addr_reg <= 10'h000;
            sh_reg <= 16'h0000;
            match_reg <= 1'b0;
            mdio_o <= 1'b0;
            mdio_oe_o <= 1'b0;
            wr_addr <= 5'h00;
            wr_data <= 16'h0000;
         end else if (mdc_rise) begin
            case (state_reg)
               S_PRE: begin
                  if (!mdio_i && cnt_reg == pbc_pkg::PREAMBLE_LAST) begin
                     state_reg <= S_ST;
                  end else if (mdio_i && cnt_reg != pbc_pkg::PREAMBLE_LAST) begin
                     cnt_reg <= cnt_reg + 5'h01;
                  end else if (!mdio_i) begin
                     cnt_reg <= 5'h00;
                  end
               end
               S_ST: begin
                  cnt_reg <= 5'h00;
                  state_reg <= mdio_i ? S_OP : S_PRE;
               end
               S_OP: begin
                  op_reg <= {op_reg[0], mdio_i};
                  cnt_reg <= cnt_reg + 5'h01;
                  if (cnt_reg == 5'h01) begin
                     cnt_reg <= 5'h00;
                     state_reg <= S_ADDR;
                  end
               end
               S_ADDR: begin
                  addr_reg <= {addr_reg[8:0], mdio_i};
                  cnt_reg <= cnt_reg + 5'h01;
                  if (cnt_reg == 5'h09) begin
                     cnt_reg <= 5'h00;
                     match_reg <= (addr_reg[8:4] == straps_q.addr);
                     state_reg <= S_TA;
                  end
               end
               S_TA: begin
                  cnt_reg <= cnt_reg + 5'h01;
                  if (cnt_reg == 5'h00) begin
                     if (match_reg && op_reg == pbc_pkg::OP_READ) begin
                        mdio_oe_o <= 1'b1;
                        mdio_o <= 1'b0;
                     end
                  end else begin
                     mdio_o <= rd_data[15];
                     sh_reg <= {rd_data[14:0], 1'b0};
                     cnt_reg <= 5'h00;
                     state_reg <= S_DATA;
                  end
               end
               S_DATA: begin
                  cnt_reg <= cnt_reg + 5'h01;
                  mdio_o <= sh_reg[15];
                  sh_reg <= {sh_reg[14:0], mdio_i};
                  if (cnt_reg == 5'h0F) begin
                     mdio_oe_o <= 1'b0;
                     mdio_o <= 1'b0;
                     cnt_reg <= 5'h00;
                     state_reg <= S_PRE;
                     if (match_reg && op_reg == pbc_pkg::OP_WRITE) begin
                        wr_stb <= 1'b1;
                        wr_addr <= addr_reg[4:0];
                        wr_data <= {sh_reg[14:0], mdio_i};
                     end
                  end
               end
               default: begin
                  state_reg <= S_PRE;
               end
            endcase
         end
      end
   end

   // Register write decode and reset requests
   assign wr_bmc = wr_stb && hits(wr_addr, pbc_pkg::REG_BASIC_MODE_CONTROL);
   assign wr_gctrl = wr_stb && hits(wr_addr, pbc_pkg::REG_GLOBAL_CTRL);
   assign req[pbc_pkg::SEQ_SW] = wr_bmc && wr_data[pbc_pkg::BMC_RESET];
   assign req[pbc_pkg::SEQ_GLOBAL] = wr_gctrl && wr_data[pbc_pkg::GCTRL_RESET];
   assign req[pbc_pkg::SEQ_RESTART] = wr_gctrl && wr_data[pbc_pkg::GCTRL_RESTART];

   // Default control word with strapped negotiation and duplex
   always_comb begin
      bmc_default = pbc_pkg::BMC_RESET_VAL;
      bmc_default[pbc_pkg::BMC_AN_ENABLE] = straps_q.an_enable;
      bmc_default[pbc_pkg::BMC_DUPLEX] = straps_q.duplex;
   end

   // Next control word: self-clear, write, reset, pin override
   always_comb begin
      bmc_next = bmc_reg;
      if (an_started_i) begin
         bmc_next[pbc_pkg::BMC_AN_RESTART] = 1'b0;
      end
      if (wr_bmc) begin
         bmc_next = wr_data & pbc_pkg::BMC_WR_MASK;
         bmc_next[pbc_pkg::BMC_AN_RESTART] = wr_data[pbc_pkg::BMC_AN_RESTART] & bmc_reg[pbc_pkg::BMC_AN_ENABLE];
      end
      if (dev_rst || busy[pbc_pkg::SEQ_SW] || busy[pbc_pkg::SEQ_GLOBAL]) begin
         bmc_next = bmc_default;
      end
      if (!power_down_input_n_i) begin
         bmc_next[pbc_pkg::BMC_POWER_DOWN] = 1'b1;
      end
   end

   // Control word storage
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         bmc_reg <= bmc_next;
      end
   end

   // Port configuration, cleared only by device or global reset
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (dev_rst || busy[pbc_pkg::SEQ_GLOBAL]) begin
            pcfg_reg <= pbc_pkg::PCFG_RESET_VAL;
         end else if (wr_stb && hits(wr_addr, pbc_pkg::REG_PORT_CONFIG)) begin
            pcfg_reg <= wr_data;
         end
      end
   end

   // Read data selection
   always_comb begin
      rd_data = 16'h0000;
      if (hits(addr_reg[4:0], pbc_pkg::REG_BASIC_MODE_CONTROL)) begin
         rd_data = bmc_reg & pbc_pkg::BMC_WR_MASK;
         rd_data[pbc_pkg::BMC_AN_RESTART] = bmc_reg[pbc_pkg::BMC_AN_RESTART];
         rd_data[pbc_pkg::BMC_RESET] = busy[pbc_pkg::SEQ_SW];
      end else if (hits(addr_reg[4:0], pbc_pkg::REG_PORT_CONFIG)) begin
         rd_data = pcfg_reg;
      end else if (hits(addr_reg[4:0], pbc_pkg::REG_GLOBAL_CTRL)) begin
         rd_data[pbc_pkg::GCTRL_RESET] = busy[pbc_pkg::SEQ_GLOBAL];
         rd_data[pbc_pkg::GCTRL_RESTART] = busy[pbc_pkg::SEQ_RESTART];
      end
   end

   assign pd = bmc_reg[pbc_pkg::BMC_POWER_DOWN] | ~power_down_input_n_i;

   // Power and sleep outputs
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (dev_rst) begin
            power_down_o <= 1'b0;
            crystal_pad_off_o <= 1'b0;
            sleep_o <= 1'b0;
            nlp_tx_en_o <= 1'b0;
         end else begin
            power_down_o <= pd;
            crystal_pad_off_o <= pd && pcfg_reg[pbc_pkg::PCFG_DEEP_PD];
            sleep_o <= !pd && pcfg_reg[pbc_pkg::PCFG_SLEEP_HI] && !link_partner_i;
            nlp_tx_en_o <= !pd && !(pcfg_reg[pbc_pkg::PCFG_SLEEP_HI:pbc_pkg::PCFG_SLEEP_LO] == pbc_pkg::SLEEP_PASSIVE
                                    && !link_partner_i);
         end
      end
   end

   // Speed, duplex and negotiation outputs
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (dev_rst) begin
            speed_o <= 2'h0;
            duplex_o <= 1'b0;
            an_enable_o <= 1'b0;
            an_restart_o <= 1'b0;
         end else begin
            an_enable_o <= bmc_reg[pbc_pkg::BMC_AN_ENABLE];
            an_restart_o <= wr_bmc && wr_data[pbc_pkg::BMC_AN_RESTART] && bmc_reg[pbc_pkg::BMC_AN_ENABLE];
            if (bmc_reg[pbc_pkg::BMC_AN_ENABLE]) begin
               speed_o <= an_speed_i;
               duplex_o <= an_duplex_i;
            end else begin
               speed_o <= {bmc_reg[pbc_pkg::BMC_SPEED_MSB], bmc_reg[pbc_pkg::BMC_SPEED_LSB]};
               duplex_o <= bmc_reg[pbc_pkg::BMC_DUPLEX];
            end
         end
      end
   end

   // Address and circuit restart outputs
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (rst_i) begin
            port_address_o <= pbc_pkg::PHY_ADDR_RESET;
            circuit_restart_o <= 1'b1;
         end else begin
            port_address_o <= straps_q.addr;
            circuit_restart_o <= dev_rst || busy[pbc_pkg::SEQ_GLOBAL] || busy[pbc_pkg::SEQ_RESTART];
         end
      end
   end
endmodule

// ===== pbc_pkg.sv
// Shared constants and types for the port control block
package pbc_pkg;
   // Register addresses on the management bus
   localparam logic [4:0] REG_BASIC_MODE_CONTROL = 5'h00;
   localparam logic [4:0] REG_PORT_CONFIG = 5'h10;
   localparam logic [4:0] REG_GLOBAL_CTRL = 5'h1F;

   // Field positions of basic_mode_control
   localparam int BMC_RESET = 15;
   localparam int BMC_LOOPBACK = 14;
   localparam int BMC_SPEED_LSB = 13;
   localparam int BMC_AN_ENABLE = 12;
   localparam int BMC_POWER_DOWN = 11;
   localparam int BMC_ISOLATE = 10;
   localparam int BMC_AN_RESTART = 9;
   localparam int BMC_DUPLEX = 8;
   localparam int BMC_COL_TEST = 7;
   localparam int BMC_SPEED_MSB = 6;

   // Field positions of port_config_reg and global control
   localparam int PCFG_DEEP_PD = 7;
   localparam int PCFG_SLEEP_HI = 9;
   localparam int PCFG_SLEEP_LO = 8;
   localparam int GCTRL_RESET = 15;
   localparam int GCTRL_RESTART = 14;

   // Reset values and write masks
   localparam logic [15:0] BMC_RESET_VAL = 16'h0040;
   localparam logic [15:0] BMC_WR_MASK = 16'h7FC0;
   localparam logic [15:0] PCFG_RESET_VAL = 16'h0000;
   localparam logic [4:0] PHY_ADDR_RESET = 5'h00;

   // Sleep field encodings
   localparam logic [1:0] SLEEP_ACTIVE = 2'h2;
   localparam logic [1:0] SLEEP_PASSIVE = 2'h3;

   // Management frame fields
   localparam logic [4:0] PREAMBLE_LAST = 5'h1F;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;

   // Timing: clock period and internal sequence lengths
   localparam int CLK_PERIOD_NS = 50;
   localparam int SW_RESET_NS = 1000;
   localparam int GLOBAL_RESET_NS = 1000;
   localparam int RESTART_NS = 1000;
   localparam int SW_RESET_CYC = (SW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GLOBAL_RESET_CYC = (GLOBAL_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESTART_CYC = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Index of each internal reset sequence
   localparam int SEQ_SW = 0;
   localparam int SEQ_GLOBAL = 1;
   localparam int SEQ_RESTART = 2;

   // Strap bundle
   typedef struct packed {
      logic [4:0] addr;
      logic an_enable;
      logic duplex;
   } pbc_strap_t;

   // One direction of the MAC data interface
   typedef struct packed {
      logic en;
      logic er;
      logic [7:0] data;
   } pbc_mii_t;
endpackage

// ===== pbc_reset_ctrl.sv
// Reset sequencing and strap latching
`timescale 1ns/1ps
module pbc_reset_ctrl (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic rst_i,
   input wire logic hw_reset_n_i,
   input wire logic [2:0] req_i,
   input wire pbc_pkg::pbc_strap_t straps_i,
   output pbc_pkg::pbc_strap_t straps_o,
   output logic [2:0] busy_o,
   output logic dev_rst_o
);
   // Sequence length for each kind of reset
   function automatic logic [7:0] span(input int k);
      case (k)
         pbc_pkg::SEQ_SW: span = 8'(pbc_pkg::SW_RESET_CYC);
         pbc_pkg::SEQ_GLOBAL: span = 8'(pbc_pkg::GLOBAL_RESET_CYC);
         default: span = 8'(pbc_pkg::RESTART_CYC);
      endcase
   endfunction

   pbc_pkg::pbc_strap_t straps_reg;

   // Power-on reset or the reset pin both reset the whole device
   assign dev_rst_o = rst_i | ~hw_reset_n_i;

   // One down-counter per reset kind
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_seq
         logic [7:0] cnt_reg;
         always_ff @(posedge clk_i) begin
            if (ce_i) begin
               if (dev_rst_o) begin
                  cnt_reg <= 8'h00;
               end else if (cnt_reg != 8'h00) begin
                  cnt_reg <= cnt_reg - 8'h01;
               end else if (req_i[g]) begin
                  cnt_reg <= span(g);
               end
            end
         end
         assign busy_o[g] = (cnt_reg != 8'h00);
      end
   endgenerate

   // Straps re-sampled on device or software reset, kept on global reset
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (dev_rst_o) begin
            straps_reg <= straps_i;
         end else if (req_i[pbc_pkg::SEQ_SW] && !busy_o[pbc_pkg::SEQ_SW]) begin
            straps_reg <= straps_i;
         end
      end
   end

   assign straps_o = straps_reg;
endmodule

// ===== pbc_mii_path.sv
// MAC-side data path: loopback, isolate and collision test
`timescale 1ns/1ps
module pbc_mii_path (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic rst_i,
   input wire logic loopback_i,
   input wire logic isolate_i,
   input wire logic col_test_i,
   input wire pbc_pkg::pbc_mii_t mac_tx_i,
   input wire pbc_pkg::pbc_mii_t line_rx_i,
   input wire logic line_col_i,
   output pbc_pkg::pbc_mii_t mac_rx_o,
   output pbc_pkg::pbc_mii_t line_tx_o,
   output logic col_o
);
   // Receive towards the MAC
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (rst_i || isolate_i) begin
            mac_rx_o <= '0;
         end else if (loopback_i) begin
            mac_rx_o <= mac_tx_i;
         end else begin
            mac_rx_o <= line_rx_i;
         end
      end
   end

   // Transmit towards the line, quiet in loopback or isolate
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (rst_i || isolate_i || loopback_i) begin
            line_tx_o <= '0;
         end else begin
            line_tx_o <= mac_tx_i;
         end
      end
   end

   // Collision follows transmit enable one cycle later in test mode
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (rst_i || isolate_i) begin
            col_o <= 1'b0;
         end else if (col_test_i) begin
            col_o <= mac_tx_i.en;
         end else begin
            col_o <= line_col_i;
         end
      end
   end
endmodule

// ===== pbc_smi_host.sv
// Management station model that frames reads and writes on the serial bus
`timescale 1ns/1ps
module pbc_smi_host (
   input wire logic clk_i,
   input wire logic mdio_d_i,
   input wire logic mdio_oe_i,
   output logic mdc_o,
   output logic mdio_o
);
   logic drv = 1'b0;
   logic hbit = 1'b1;
   logic oe_seen = 1'b0;
   // Line level: pull-up wins when neither side drives
   assign mdio_o = mdio_oe_i ? mdio_d_i : (drv ? hbit : 1'b1);
   initial mdc_o = 1'b0;
   // One frame, four clocks per bit, clock parked low between frames
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
         input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] f;
      f = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
      rd = 16'h0000;
      oe_seen = 1'b0;
      for (int i = 63; i >= 0; i--) begin
         @(posedge clk_i);
         mdc_o <= 1'b0;
         drv <= !(op == pbc_pkg::OP_READ && i <= 17); // Released from turnaround on
         hbit <= f[i];
         @(posedge clk_i);
         @(posedge clk_i);
         if (i < 16) rd[i] = mdio_o;
         oe_seen = oe_seen | mdio_oe_i;
         mdc_o <= 1'b1;
         @(posedge clk_i);
      end
      @(posedge clk_i);
      mdc_o <= 1'b0;
      drv <= 1'b0;
   endtask
endmodule

// ===== pbc_port_ctrl_properties.sv
// Temporal checks on the pins of the port control block
`timescale 1ns/1ps
module pbc_port_ctrl_properties (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic hw_reset_n_i,
   input wire logic power_down_input_n_i,
   input wire logic [4:0] station_address_straps_i,
   input wire logic strap_narrow_i,
   input wire logic mdc_i,
   input wire logic mdio_o,
   input wire logic mdio_oe_o,
   input wire logic link_partner_i,
   input wire logic [4:0] port_address_o,
   input wire logic power_down_o,
   input wire logic crystal_pad_off_o,
   input wire logic sleep_o,
   input wire logic nlp_tx_en_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || !hw_reset_n_i);
   // Turnaround: drive starts with a zero
   sequence s_drive_start;
      $rose(mdio_oe_o) ##0 !mdio_o;
   endsequence
   // Pin held low for three samples
   sequence s_pin_low;
      !power_down_input_n_i [*3];
   endsequence
   AST_PD_PIN: assert property (s_pin_low |-> power_down_o)
      else $error("power down pin ignored");
   AST_CRYSTAL: assert property (crystal_pad_off_o |-> power_down_o)
      else $error("crystal pad off outside power down");
   AST_SLEEP_PD: assert property (sleep_o |-> !power_down_o)
      else $error("sleep during power down");
   AST_SLEEP_WAKE: assert property (link_partner_i |=> !sleep_o)
      else $error("no wake on link partner");
   AST_NLP: assert property (!nlp_tx_en_o && !power_down_o |-> !$past(link_partner_i))
      else $error("link pulses stopped with partner present");
   AST_TA_ZERO: assert property ($rose(mdio_oe_o) |-> !mdio_o)
      else $error("turnaround bit not zero");
   AST_OE_HOLD: assert property (s_drive_start |=> mdio_oe_o [*8])
      else $error("read drive dropped early");
   AST_OE_TIMING: assert property ($rose(mdio_oe_o) |-> $past(mdc_i) && !$past(mdc_i, 2))
      else $error("drive not tied to clock rise");
   AST_RESET_ADDR: assert property ($fell(rst_i) |=>
      port_address_o == ({~$past(strap_narrow_i), 4'hF} & $past(station_address_straps_i)))
      else $error("address not latched from straps");
endmodule
bind pbc_port_ctrl pbc_port_ctrl_properties i_pbc_port_ctrl_properties (.clk_i(clk_i), .rst_i(rst_i),
   .hw_reset_n_i(hw_reset_n_i), .power_down_input_n_i(power_down_input_n_i),
   .station_address_straps_i(station_address_straps_i), .strap_narrow_i(strap_narrow_i), .mdc_i(mdc_i),
   .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .link_partner_i(link_partner_i), .port_address_o(port_address_o),
   .power_down_o(power_down_o), .crystal_pad_off_o(crystal_pad_off_o), .sleep_o(sleep_o),
   .nlp_tx_en_o(nlp_tx_en_o));

// ===== tb_top.sv
// Self-checking bench for the port control block
`timescale 1ns/1ps
module tb_top;
   localparam logic [4:0] BMC = pbc_pkg::REG_BASIC_MODE_CONTROL;
   localparam logic [4:0] PCF = pbc_pkg::REG_PORT_CONFIG;
   localparam logic [4:0] GCT = pbc_pkg::REG_GLOBAL_CTRL;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic hw_n = 1'b1;
   logic pd_n = 1'b1;
   logic [4:0] straps = 5'h13;
   logic narrow = 1'b0;
   logic link = 1'b0;
   logic an_start = 1'b0;
   logic [1:0] an_speed = 2'h1;
   logic an_dup = 1'b0;
   pbc_pkg::pbc_mii_t mac_tx = '0;
   pbc_pkg::pbc_mii_t mac_rx, line_tx;
   logic mdc, mdio, mdio_d, mdio_oe, col, pd, xtal, slp, nlp, dup, an_rs, crst;
   logic [1:0] speed;
   logic [4:0] paddr;
   logic [4:0] pa = 5'h13;
   logic crst_seen = 1'b0;
   logic [15:0] v;
   int n_rs = 0;
   int n_mismatch = 0;
   int compares = 0;
   // Clock
   initial forever #25 clk_i = ~clk_i;
   pbc_port_ctrl i_pbc_port_ctrl (.clk_i(clk_i), .ce_i(1'b1), .rst_i(rst_i), .hw_reset_n_i(hw_n),
      .power_down_input_n_i(pd_n), .station_address_straps_i(straps), .strap_narrow_i(narrow),
      .strap_an_enable_i(1'b1), .strap_duplex_i(1'b1), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(mdio_d),
      .mdio_oe_o(mdio_oe), .link_partner_i(link), .an_started_i(an_start), .an_speed_i(an_speed),
      .an_duplex_i(an_dup), .mac_tx_i(mac_tx), .line_rx_i('0), .line_col_i(1'b0), .mac_rx_o(mac_rx),
      .line_tx_o(line_tx), .col_o(col), .port_address_o(paddr), .power_down_o(pd), .crystal_pad_off_o(xtal),
      .sleep_o(slp), .nlp_tx_en_o(nlp), .speed_o(speed), .duplex_o(dup), .an_enable_o(),
      .an_restart_o(an_rs), .circuit_restart_o(crst));
   pbc_smi_host i_pbc_smi_host (.clk_i(clk_i), .mdio_d_i(mdio_d), .mdio_oe_i(mdio_oe), .mdc_o(mdc),
      .mdio_o(mdio));
   // Pulse and restart monitors
   always @(posedge clk_i) begin
      if (an_rs === 1'b1) n_rs++;
      if (crst === 1'b1 && !rst_i && hw_n) crst_seen = 1'b1;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] x;
      i_pbc_smi_host.xfer(pbc_pkg::OP_WRITE, pa, ra, d, x);
      repeat (3) @(posedge clk_i);
   endtask
   task automatic rc(input logic [4:0] ra, input logic [15:0] exp);
      logic [15:0] x;
      i_pbc_smi_host.xfer(pbc_pkg::OP_READ, pa, ra, 16'h0000, x);
      check(x, exp);
   endtask
   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (60000) @(posedge clk_i);
      n_mismatch++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check(16'(paddr), 16'h0013);
      rc(BMC, 16'h1140);
      check(16'(speed), 16'h0001);
      check(16'(dup), 16'h0000);
      an_dup <= 1'b1;
      repeat (2) @(posedge clk_i);
      check(16'(dup), 16'h0001);
      pa = 5'h0C;
      rc(BMC, 16'hFFFF);
      check(16'(i_pbc_smi_host.oe_seen), 16'h0000);
      pa = 5'h13;
      wr(BMC, 16'h1340);
      check(16'(n_rs), 16'h0001);
      rc(BMC, 16'h1340);
      an_start <= 1'b1;
      @(posedge clk_i);
      an_start <= 1'b0;
      rc(BMC, 16'h1140);
      $display("test reset and negotiation done");
      // Manual speed codes with reserved bits written as ones
      for (int k = 0; k < 4; k++) begin
         v = 16'h013F | {2'b00, k[0], 6'h00, k[1], 6'h00};
         wr(BMC, v);
         rc(BMC, v & 16'hFFC0);
         check(16'(speed), 16'(k[1:0]));
         check(16'(dup), 16'h0001);
      end
      wr(BMC, 16'h0200);
      rc(BMC, 16'h0000);
      check(16'(n_rs), 16'h0001);
      $display("test speed done");
      wr(BMC, 16'h4000);
      mac_tx <= pbc_pkg::pbc_mii_t'(10'h2A5);
      repeat (3) @(posedge clk_i);
      check(16'(mac_rx), 16'h02A5);
      check(16'(line_tx), 16'h0000);
      wr(BMC, 16'h0400);
      check(16'(mac_rx), 16'h0000);
      rc(BMC, 16'h0400);
      wr(BMC, 16'h0080);
      check(16'(col), 16'h0001);
      mac_tx <= '0;
      repeat (3) @(posedge clk_i);
      check(16'(col), 16'h0000);
      $display("test data path done");
      pd_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      check(16'(pd), 16'h0001);
      pd_n <= 1'b1;
      rc(BMC, 16'h0880);
      wr(BMC, 16'h0000);
      check(16'(pd), 16'h0000);
      wr(PCF, 16'h0080);
      wr(BMC, 16'h0800);
      check(16'(xtal), 16'h0001);
      straps <= 5'h0A;
      wr(BMC, 16'h8000);
      repeat (30) @(posedge clk_i);
      pa = 5'h0A;
      check(16'(pd), 16'h0000);
      check(16'(paddr), 16'h000A);
      rc(BMC, 16'h1140);
      rc(PCF, 16'h0080);
      $display("test power down done");
      wr(PCF, 16'h0300);
      check(16'(slp), 16'h0001);
      check(16'(nlp), 16'h0000);
      link <= 1'b1;
      repeat (3) @(posedge clk_i);
      check(16'({slp, nlp}), 16'h0001);
      link <= 1'b0;
      wr(PCF, 16'h0200);
      check(16'({slp, nlp}), 16'h0003);
      $display("test sleep done");
      straps <= 5'h11;
      wr(GCT, 16'h8000);
      repeat (30) @(posedge clk_i);
      check(16'(paddr), 16'h000A);
      rc(PCF, 16'h0000);
      wr(BMC, 16'h4000);
      crst_seen = 1'b0;
      wr(GCT, 16'h4000);
      repeat (30) @(posedge clk_i);
      check(16'(crst_seen), 16'h0001);
      rc(BMC, 16'h4000);
      $display("test global reset done");
      straps <= 5'h10;
      narrow <= 1'b1;
      hw_n <= 1'b0;
      repeat (25) @(posedge clk_i);
      hw_n <= 1'b1;
      repeat (2) @(posedge clk_i);
      pa = 5'h00;
      check(16'(paddr), 16'h0000);
      rc(BMC, 16'h1140);
      $display("test hardware reset done");
      end_sim();
   end
endmodule
